/* design/fms_pkg.sv */
package fms_pkg;
    // driver population
    localparam int NUM_HB = 4;                     // half-bridge outputs
    localparam int NUM_HS = 4;                     // high-side outputs
    localparam int NUM_DRV = NUM_HB + NUM_HS;      // all driver outputs
    localparam int NUM_AIN = 4;                    // analog input pins
    // adc self-test channels
    localparam logic [4:0] CH_RATIO_HI = 5'h19;    // ratiometric upper divider point
    localparam logic [4:0] CH_RATIO_LO = 5'h1a;    // ratiometric lower divider point
    localparam logic [4:0] CH_HALF_REF = 5'h1b;    // half-reference, absolute test
    localparam logic [4:0] CH_IND_REF = 5'h1c;     // independent reference
    localparam logic [4:0] CH_FIVE_V = 5'h1d;      // scaled five volt regulator
    localparam logic [9:0] EXP_RATIO_HI = 10'h2aa; // 682
    localparam logic [9:0] EXP_RATIO_LO = 10'h155; // 341
    localparam logic [9:0] EXP_MID = 10'h200;      // 512
    localparam logic [9:0] TOL_15 = 10'h00f;       // 15
    localparam logic [9:0] TOL_30 = 10'h01e;       // 30
    localparam logic [9:0] TOL_50 = 10'h032;       // 50
    // timing
    localparam int CLK_MHZ = 100;                  // fast oscillator rate
    localparam int SLOW_PERIOD_NS = 8000;          // 125 kHz slow oscillator period
    localparam int SLOW_TIMEOUT_NS = 2 * SLOW_PERIOD_NS; // no edge for two periods
    localparam int SLOW_TIMEOUT_CYC = SLOW_TIMEOUT_NS * CLK_MHZ / 1000; // 1600 cycles
    localparam int SPS_MAX = 125000;               // fastest allowed self-test rate
    localparam int CONV_MIN_NS = 1000000000 / SPS_MAX; // 8000 ns between conversions
    localparam int CONV_MIN_CYC = CONV_MIN_NS / 10 * CLK_MHZ / 100; // 800 cycles
    // status word layout
    localparam int ST_OVT = 0;                     // over-temperature latched
    localparam int ST_OV = 1;                      // over-voltage latched
    localparam int ST_UV = 2;                      // under-voltage latched
    localparam int ST_CLK = 3;                     // slow clock failure latched
    localparam int ST_OL = 4;                      // open-load flags base
    localparam int ST_SB = ST_OL + NUM_DRV;        // short-to-battery flags base
    localparam int ST_SG = ST_SB + NUM_DRV;        // half-bridge short-to-ground base
    localparam int ST_AIN = ST_SG + NUM_HB;        // analog input floating/short base
    localparam int ST_SNS = ST_AIN + NUM_AIN;      // sensor supply fault
    localparam int ST_W = ST_SNS + 1;              // status word width
    localparam logic [ST_W-1:0] ST_RESET = '0;     // all flags clear after reset
endpackage

/* design/fms_if.sv */
`timescale 1ns/1ps
// link between the fault monitor and the microcontroller-side agent
interface fms_if;
    logic irq;                            // level, any enabled flag set
    logic drv_off;                        // level, drivers forced off
    logic [fms_pkg::ST_W-1:0] status;     // latched flags, spi readable
    logic [fms_pkg::ST_W-1:0] clear;      // one-cycle clear strobes per flag
    logic [fms_pkg::ST_W-1:0] irq_en;     // per flag interrupt enable
    logic ov_off_dis;                     // disable over-voltage shutdown
    logic uv_dis;                         // disable under-voltage detection
    logic [4:0] adc_input_select;         // adc channel code
    logic adc_start;                      // one-cycle conversion start
    logic adc_done;                       // one-cycle conversion done
    logic [9:0] adc_result;               // conversion result
    logic sensor_pos_switch_enable;       // sensor supply high switch
    logic sensor_neg_switch_enable;       // sensor supply low switch
    modport dev (output irq, drv_off, status, adc_done, adc_result,
        input clear, irq_en, ov_off_dis, uv_dis, adc_input_select, adc_start,
        sensor_pos_switch_enable, sensor_neg_switch_enable);
    modport mcu (input irq, drv_off, status, adc_done, adc_result,
        output clear, irq_en, ov_off_dis, uv_dis, adc_input_select, adc_start,
        sensor_pos_switch_enable, sensor_neg_switch_enable);
endinterface

/* design/fms_monitor.sv */
`timescale 1ns/1ps
module fms_monitor (
    input wire logic CLK,                           // fast oscillator clock
    input wire logic RST,                           // synchronous reset, active high
    fms_if.dev LNK,                                 // microcontroller side
    input wire logic OVT_CMP,                       // over-temperature comparator
    input wire logic OV_CMP,                        // main_supply_pin above upper limit
    input wire logic UV_CMP,                        // main_supply_pin below lower limit
    input wire logic SLOW_OSCILLATOR,               // 125 kHz clock being watched
    input wire logic [fms_pkg::NUM_DRV-1:0] OL_DET, // open-load check result
    input wire logic [fms_pkg::NUM_DRV-1:0] SB_DET, // short-to-battery check result
    input wire logic [fms_pkg::NUM_HB-1:0] SG_DET,  // half-bridge short-to-ground result
    input wire logic [fms_pkg::NUM_HS-1:0] HS_SG_DET, // high-side short to ground
    input wire logic [fms_pkg::NUM_AIN-1:0] AIN_DET, // analog_input_pin float/short
    input wire logic SNS_DET,                       // sensor supply short/open
    input wire logic OC_IN,                         // existing over-current event
    input wire logic [9:0] ADC_RAW,                 // converter output
    input wire logic ADC_RAW_VLD,                   // converter finished
    output logic ADC_GO,                            // converter start
    output logic [4:0] ADC_MUX,                     // converter input select
    output logic SNS_POS_EN,                        // sensor supply high switch
    output logic SNS_NEG_EN,                        // sensor supply low switch
    output logic OC_OUT                             // over-current incl. high-side shorts
);
    localparam int TO_W = $clog2(fms_pkg::SLOW_TIMEOUT_CYC + 1); // timeout counter width
    localparam logic [TO_W-1:0] TO_MAX = TO_W'(fms_pkg::SLOW_TIMEOUT_CYC); // timeout limit

    logic [fms_pkg::ST_W-1:0] flags;      // sticky flags
    logic [fms_pkg::ST_W-1:0] ev;         // event set per flag
    logic [fms_pkg::ST_W-1:0] next_flags; // next flag value
    logic slow_s1;                        // slow clock sync stage 1
    logic slow_s2;                        // slow clock sync stage 2
    logic slow_d;                         // delayed for edge detect
    logic [TO_W-1:0] to_cnt;              // cycles since last slow edge
    logic drv_off;                        // combined driver shutdown
    logic [9:0] result;                   // held conversion result
    logic done;                           // conversion done pulse

    // event vector; high-side ground shorts are not captured as flags
    wire slow_edge = slow_s2 ^ slow_d;    // any slow clock transition
    wire clk_fail = (to_cnt == TO_MAX);   // no edge for two periods
    wire uv_ev = UV_CMP & ~LNK.uv_dis;
    assign ev[fms_pkg::ST_OVT] = OVT_CMP;
    assign ev[fms_pkg::ST_OV] = OV_CMP;
    assign ev[fms_pkg::ST_UV] = uv_ev;
    assign ev[fms_pkg::ST_CLK] = clk_fail;
    assign ev[fms_pkg::ST_OL +: fms_pkg::NUM_DRV] = OL_DET;
    assign ev[fms_pkg::ST_SB +: fms_pkg::NUM_DRV] = SB_DET;
    assign ev[fms_pkg::ST_SG +: fms_pkg::NUM_HB] = SG_DET;
    assign ev[fms_pkg::ST_AIN +: fms_pkg::NUM_AIN] = AIN_DET;
    assign ev[fms_pkg::ST_SNS] = SNS_DET;

    // set wins over clear so a same-cycle event is never lost
    assign next_flags = ev | (flags & ~LNK.clear);

    // shutdown: temp always, ov unless disabled, uv; clock failure excluded
    assign drv_off = flags[fms_pkg::ST_OVT]
        | (flags[fms_pkg::ST_OV] & ~LNK.ov_off_dis)
        | flags[fms_pkg::ST_UV];

    // high-side ground shorts surface as over-current only
    assign OC_OUT = OC_IN | (|HS_SG_DET);

    // flag register
    always_ff @(posedge CLK)
    begin
        if (RST)
            flags <= fms_pkg::ST_RESET;
        else
            flags <= next_flags;
    end

    // slow clock synchroniser; stage 1 feeds stage 2 only
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            slow_s1 <= 1'b0;
            slow_s2 <= 1'b0;
            slow_d <= 1'b0;
        end
        else
        begin
            slow_s1 <= SLOW_OSCILLATOR;
            slow_s2 <= slow_s1;
            slow_d <= slow_s2;
        end
    end

    // watchdog counter, saturates so failure stays asserted while stopped
    always_ff @(posedge CLK)
    begin
        if (RST || slow_edge)
            to_cnt <= '0;
        else if (!clk_fail)
            to_cnt <= to_cnt + TO_W'(1);
    end

    // adc path: result captured on completion for the mcu
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            result <= '0;
            done <= 1'b0;
        end
        else
        begin
            done <= ADC_RAW_VLD;
            if (ADC_RAW_VLD)
                result <= ADC_RAW;
        end
    end

    // outputs toward mcu and analog front end
    assign LNK.status = flags;
    assign LNK.irq = |(flags & LNK.irq_en);
    assign LNK.drv_off = drv_off;
    assign LNK.adc_result = result;
    assign LNK.adc_done = done;
    assign ADC_GO = LNK.adc_start;
    assign ADC_MUX = LNK.adc_input_select;
    assign SNS_POS_EN = LNK.sensor_pos_switch_enable;
    assign SNS_NEG_EN = LNK.sensor_neg_switch_enable;
endmodule // fms_monitor

/* design/fms_mcu_agent.sv */
`timescale 1ns/1ps
// software-side agent: config, clears, and adc self-test sequencing
module fms_mcu_agent (
    input wire logic CLK,                                  // system clock
    input wire logic RST,                                  // synchronous reset
    fms_if.mcu LNK,                                        // device side
    input wire logic [fms_pkg::ST_W-1:0] CLR_REQ,          // flag clear strobes
    input wire logic [fms_pkg::ST_W-1:0] IRQ_EN,           // interrupt enables
    input wire logic OV_OFF_DIS,                           // disable ov shutdown
    input wire logic UV_DIS,                               // disable uv detection
    input wire logic TEST_GO,                              // start self-test on channel
    input wire logic [4:0] TEST_CH,                        // self-test channel
    output logic TEST_BUSY,                                // self-test running
    output logic TEST_DONE,                                // one-cycle completion
    output logic TEST_PASS,                                // result inside window
    output logic [9:0] TEST_RES                            // captured result
);
    typedef enum logic [1:0] {IDLE, SETTLE, CONV, GAP} fms_st_e; // sequence states
    localparam int GAP_W = $clog2(fms_pkg::CONV_MIN_CYC + 1); // spacing counter width
    localparam logic [GAP_W-1:0] GAP_MAX = GAP_W'(fms_pkg::CONV_MIN_CYC - 1); // gap end

    fms_st_e st;                 // sequence state
    logic [4:0] ch;              // held channel
    logic [GAP_W-1:0] gap;       // spacing counter
    logic [9:0] exp_v;           // expected value
    logic [9:0] tol;             // tolerance
    logic ratio;                 // ratiometric channel selected

    // expected window per self-test channel
    always_comb
    begin
        ratio = 1'b0;
        exp_v = fms_pkg::EXP_MID;
        tol = '0;
        unique case (ch)
            fms_pkg::CH_RATIO_HI:
            begin
                exp_v = fms_pkg::EXP_RATIO_HI;
                tol = fms_pkg::TOL_15;
                ratio = 1'b1;
            end
            fms_pkg::CH_RATIO_LO:
            begin
                exp_v = fms_pkg::EXP_RATIO_LO;
                tol = fms_pkg::TOL_15;
                ratio = 1'b1;
            end
            fms_pkg::CH_HALF_REF:
                tol = fms_pkg::TOL_15;
            fms_pkg::CH_IND_REF:
                tol = fms_pkg::TOL_30;
            fms_pkg::CH_FIVE_V:
                tol = fms_pkg::TOL_50;
            default:
                tol = '0; // other channels pass only at exact midscale
        endcase
    end

    wire in_win = (LNK.adc_result >= exp_v - tol) && (LNK.adc_result <= exp_v + tol); // window check

    // sequence: enable supply on ratio channels, convert, then hold off to keep rate low
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st <= IDLE;
            ch <= '0;
            gap <= '0;
            TEST_DONE <= 1'b0;
            TEST_PASS <= 1'b0;
            TEST_RES <= '0;
        end
        else
        begin
            TEST_DONE <= 1'b0;
            unique case (st)
                IDLE:
                begin
                    if (TEST_GO)
                    begin
                        ch <= TEST_CH;
                        st <= SETTLE;
                    end
                end
                SETTLE: st <= CONV; // switches on in the same cycle as the start pulse
                CONV: if (LNK.adc_done)
                begin
                    TEST_RES <= LNK.adc_result;
                    TEST_PASS <= in_win;
                    TEST_DONE <= 1'b1;
                    gap <= '0;
                    st <= GAP;
                end
                GAP:
                begin
                    if (gap == GAP_MAX)
                        st <= IDLE;
                    else
                        gap <= gap + GAP_W'(1);
                end
            endcase
        end
    end

    assign TEST_BUSY = (st != IDLE);
    assign LNK.clear = CLR_REQ;
    assign LNK.irq_en = IRQ_EN;
    assign LNK.ov_off_dis = OV_OFF_DIS;
    assign LNK.uv_dis = UV_DIS;
    assign LNK.adc_input_select = ch;
    assign LNK.adc_start = (st == SETTLE);
    assign LNK.sensor_pos_switch_enable = ratio && (st != IDLE);
    assign LNK.sensor_neg_switch_enable = ratio && (st != IDLE);
endmodule // fms_mcu_agent

/* test/fms_props.sv */
`timescale 1ns/1ps
// watches the monitor/agent link from the interface side
module fms_props (
    input wire logic CLK, // fast clock
    input wire logic RST, // sync reset
    input wire logic irq, // interrupt level
    input wire logic drv_off, // drivers forced off
    input wire logic [fms_pkg::ST_W-1:0] status, // latched flags
    input wire logic [fms_pkg::ST_W-1:0] clear, // clear strobes
    input wire logic [fms_pkg::ST_W-1:0] irq_en, // irq enables
    input wire logic ov_off_dis, // ov shutdown off
    input wire logic uv_dis, // uv detection off
    input wire logic [4:0] adc_input_select, // channel code
    input wire logic adc_start, // conversion start
    input wire logic adc_done, // conversion done
    input wire logic sensor_pos_switch_enable, // sensor high switch
    input wire logic sensor_neg_switch_enable // sensor low switch
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    int gap; // cycles since last start
    wire ratio_ch = adc_input_select == fms_pkg::CH_RATIO_HI || adc_input_select == fms_pkg::CH_RATIO_LO;
    // gap counter saturates so it never wraps into a false pass
    always_ff @(posedge CLK)
    begin
        if (RST)
            gap <= 100000;
        else if (adc_start)
            gap <= 0;
        else if (gap < 100000)
            gap <= gap + 1;
    end
    // converter answer arrives within a short bound
    sequence s_done_soon;
        ##[1:20] adc_done;
    endsequence
    a_irq_level: assert property (irq == |(status & irq_en))
        else $error("irq differs from enabled flags");
    a_drv_off_cause: assert property (drv_off == (status[0] | status[2] | (status[1] & !ov_off_dis)))
        else $error("drv_off differs from its causes");
    a_flag_sticky: assert property (1'b1 |=> (($past(status) & ~$past(clear) & ~status) == '0))
        else $error("flag dropped without clear");
    a_uv_gated: assert property (uv_dis && !status[fms_pkg::ST_UV] |=> !status[fms_pkg::ST_UV])
        else $error("uv flag set while disabled");
    a_done_pulse: assert property (adc_done |=> !adc_done)
        else $error("adc_done longer than a cycle");
    a_start_pulse: assert property ($rose(adc_start) |=> !adc_start)
        else $error("adc_start longer than a cycle");
    a_conv_done: assert property (adc_start |-> s_done_soon)
        else $error("no adc_done after start");
    a_conv_gap: assert property (adc_start |-> gap >= fms_pkg::CONV_MIN_CYC)
        else $error("conversions too close");
    a_ratio_switch: assert property (adc_start && ratio_ch |-> sensor_pos_switch_enable && sensor_neg_switch_enable)
        else $error("sensor supply off in ratio test");
endmodule // fms_props

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic CLK = 1'b0; // fast oscillator
    logic RST = 1'b1; // sync reset
    logic [fms_pkg::ST_W-1:0] ev = '0; // event inputs by flag position
    logic [fms_pkg::ST_W-1:0] clr = '0; // clear requests
    logic [fms_pkg::ST_W-1:0] ien = '1; // interrupt enables
    logic slow = 1'b0, run = 1'b1; // watched clock and its gate
    logic ovd = 1'b0, uvd = 1'b0, go = 1'b0, vld = 1'b0; // config, start, converter valid
    logic [3:0] hsg = '0; // high-side ground shorts
    logic [4:0] ch = '0, mux, mux_seen; // test channel, converter select
    logic [9:0] raw = '0, rv = '0, res; // converter output, table value, result
    logic adc_go, oc, busy, done, pass; // design outputs
    int err_count = 0, n_tests = 0;
    logic [4:0] tch [12] = '{5'h19, 5'h19, 5'h1a, 5'h1a, 5'h1b, 5'h1b, 5'h1c, 5'h1c, 5'h1d, 5'h1d, 5'h05, 5'h05};
    // window edges: even entries just inside, odd entries one step outside
    logic [9:0] traw [12] = '{10'h29b, 10'h2ba, 10'h164, 10'h145, 10'h1f1, 10'h210, 10'h21e, 10'h1e1,
        10'h232, 10'h1cd, 10'h200, 10'h201};
    fms_if lnk();
    fms_monitor u_fms_monitor (.CLK(CLK), .RST(RST), .LNK(lnk), .OVT_CMP(ev[fms_pkg::ST_OVT]),
        .OV_CMP(ev[fms_pkg::ST_OV]), .UV_CMP(ev[fms_pkg::ST_UV]), .SLOW_OSCILLATOR(slow),
        .OL_DET(ev[fms_pkg::ST_SB-1:fms_pkg::ST_OL]), .SB_DET(ev[fms_pkg::ST_SG-1:fms_pkg::ST_SB]),
        .SG_DET(ev[fms_pkg::ST_AIN-1:fms_pkg::ST_SG]), .HS_SG_DET(hsg), .AIN_DET(ev[fms_pkg::ST_SNS-1:fms_pkg::ST_AIN]),
        .SNS_DET(ev[fms_pkg::ST_SNS]), .OC_IN(1'b0), .ADC_RAW(raw), .ADC_RAW_VLD(vld), .ADC_GO(adc_go),
        .ADC_MUX(mux), .SNS_POS_EN(), .SNS_NEG_EN(), .OC_OUT(oc));
    fms_mcu_agent u_fms_mcu_agent (.CLK(CLK), .RST(RST), .LNK(lnk), .CLR_REQ(clr), .IRQ_EN(ien),
        .OV_OFF_DIS(ovd), .UV_DIS(uvd), .TEST_GO(go), .TEST_CH(ch), .TEST_BUSY(busy), .TEST_DONE(done),
        .TEST_PASS(pass), .TEST_RES(res));
    fms_props u_fms_props (.CLK(CLK), .RST(RST), .irq(lnk.irq), .drv_off(lnk.drv_off), .status(lnk.status),
        .clear(lnk.clear), .irq_en(lnk.irq_en), .ov_off_dis(lnk.ov_off_dis), .uv_dis(lnk.uv_dis),
        .adc_input_select(lnk.adc_input_select), .adc_start(lnk.adc_start), .adc_done(lnk.adc_done),
        .sensor_pos_switch_enable(lnk.sensor_pos_switch_enable), .sensor_neg_switch_enable(lnk.sensor_neg_switch_enable));
    // 100 MHz clock and 125 kHz watched clock, gated to simulate a stop
    always #5 CLK = ~CLK;
    always #4000 if (run) slow = ~slow;
    // converter stand-in: answers four cycles after start, then scrambles its output
    always @(posedge CLK)
    begin
        if (adc_go === 1'b1)
        begin
            mux_seen = mux;
            repeat (4) @(posedge CLK);
            #1 raw = rv;
            vld = 1'b1;
            @(posedge CLK);
            #1 raw = ~rv;
            vld = 1'b0;
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    // drop all events, then strobe every clear
    task automatic drop();
        ev = '0;
        clr = '1;
        tick(1);
        clr = '0;
        tick(3);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog: the whole run needs about 14k cycles
    initial
    begin
        #500000;
        err_count++;
        end_sim();
    end
    initial
    begin
        tick(10);
        RST = 1'b0;
        tick(4);
        // every flag but the clock flag alone: latch, interrupt, shutdown only for supply and heat
        for (int b = 0; b < fms_pkg::ST_W; b++)
        begin
            if (b == fms_pkg::ST_CLK)
                continue;
            ev[b] = 1'b1;
            tick(1);
            check("status", lnk.status, 32'(1) << b);
            check("irq", lnk.irq, 1'b1);
            check("drv_off", lnk.drv_off, 32'(b <= fms_pkg::ST_UV));
            ev = '0;
            tick(4);
            check("held", lnk.status, 32'(1) << b);
            drop();
            check("cleared", lnk.status, 0);
        end
        $display("flag latching test done");
        // clear while the event persists must lose; then shutdown disable with masked irq
        ev[fms_pkg::ST_OV] = 1'b1;
        clr[fms_pkg::ST_OV] = 1'b1;
        tick(1);
        clr = '0;
        tick(3);
        check("set wins", lnk.status[fms_pkg::ST_OV], 1'b1);
        drop();
        ovd = 1'b1;
        ien = '0;
        tick(2);
        ev[fms_pkg::ST_OV] = 1'b1;
        tick(1);
        check("ov no shutdown", lnk.drv_off, 1'b0);
        check("ov masked irq", lnk.irq, 1'b0);
        drop();
        ovd = 1'b0;
        ien = '1;
        uvd = 1'b1;
        tick(2);
        ev[fms_pkg::ST_UV] = 1'b1;
        tick(3);
        check("uv disabled", {lnk.drv_off, lnk.status}, 0);
        drop();
        uvd = 1'b0;
        hsg = 4'h4;
        tick(1);
        check("hs gnd short", {oc, lnk.status}, 32'(1) << fms_pkg::ST_W);
        hsg = '0;
        tick(1);
        check("oc idle", oc, 1'b0);
        $display("disable and mask test done");
        // stop the watched clock for longer than two of its periods
        tick(1000);
        check("clock alive", lnk.status[fms_pkg::ST_CLK], 1'b0);
        run = 1'b0;
        tick(1700);
        // flag and irq set, drivers left running
        check("clock fail", {lnk.drv_off, lnk.irq, lnk.status}, (32'(1) << fms_pkg::ST_W) | (32'(1) << fms_pkg::ST_CLK));
        run = 1'b1;
        tick(900);
        drop();
        check("clock recovered", lnk.status, 0);
        $display("slow clock test done");
        // self-test channels at both window edges, paced by the agent's spacing
        for (int i = 0; i < 12; i++)
        begin
            rv = traw[i];
            ch = tch[i];
            go = 1'b1;
            tick(1);
            go = 1'b0;
            for (int w = 0; w < 100 && done !== 1'b1; w++)
                tick(1);
            check("pass", pass, 32'(i % 2 == 0));
            check("result", res, traw[i]);
            check("channel", mux_seen, tch[i]);
            for (int w = 0; w < 1000 && busy !== 1'b0; w++)
                tick(1);
        end
        $display("adc self-test done");
        end_sim();
    end
endmodule // tb_top
